// ==== include/rasp_pkg.sv ====
/*
  constants for the reset address strap and sense pin block: target
  addresses, internal register offsets, field positions, reset values
  and timing counts. assumes a single 100 MHz clock domain.
*/
package rasp_pkg;
  // ---------------------------------------------------------------
  // target addresses (8-bit write form)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STRAP_LO = 8'hb0;
  localparam logic [7:0] ADDR_STRAP_HI = 8'hb2;
  // ---------------------------------------------------------------
  // internal registers
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STAT      = 8'h01;
  localparam int         CTRL_SEL_BIT  = 0;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam int         STAT_OUT_BIT  = 0;
  localparam int         STAT_ADDR_BIT = 1;
  localparam int         STAT_INT_BIT  = 2;
  // ---------------------------------------------------------------
  // timing and sizes
  // ---------------------------------------------------------------
  localparam int         NUM_PORTS     = 4;
  localparam logic [1:0] CAPTURE_WAIT  = 2'h2;  // cycles for the strap to pass its synchroniser
  localparam int         HPD_TOGGLE_CYCLES = 16;
endpackage

// ==== rtl/rasp_sync.sv ====
/*
  two-flop synchroniser for a vector of asynchronous pin levels.
  assumes each bit is an independent level; no bus coherency.
*/
`timescale 1ns/1ps
module rasp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  initial begin
    if (W < 1) $error("rasp_sync: width must be at least one");
  end

  // first flop feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // rasp_sync

// ==== rtl/rasp_top.sv ====
/*
  strap capture, sense output mux, open-drain interrupt and the
  configuration serial target with a control and a status register.
  assumes i_resetn is the combined power-on and external reset, and
  that pins are resolved from the output enables outside.
*/
`timescale 1ns/1ps
module rasp_top #(
  parameter int NP       = rasp_pkg::NUM_PORTS,
  parameter int HPD_CYC  = rasp_pkg::HPD_TOGGLE_CYCLES
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // address strap and sense pin
  input  wire logic                  i_strap_in,
  output logic                       o_strap_out,
  output logic                       o_strap_oe,
  // port status from the receivers
  input  wire logic [NP-1:0]         i_port_5v_detect,
  input  wire logic [NP-1:0]         i_tmds_clk_det,
  input  wire logic [$clog2(NP)-1:0] i_sel_port,
  // interrupt pin
  input  wire logic                  i_int_req,
  input  wire logic                  i_int_in,
  output logic                       o_int_out,
  output logic                       o_int_oe,
  // configuration serial port
  input  wire logic                  i_cfg_serial_clock,
  input  wire logic                  i_cfg_serial_data_in,
  output logic                       o_cfg_serial_data_out,
  output logic                       o_cfg_serial_data_oe,
  // boot and hot plug
  output logic                       o_boot_reload,
  output logic                       o_hpd_low
);
  // ---------------------------------------------------------------
  // synchronised pins
  // ---------------------------------------------------------------
  localparam int SW = 2 * NP + 4;
  logic [SW-1:0] pins_s;
  logic          strap_s, scl_s, sda_s, int_s;
  logic [NP-1:0] det5v_s, tmds_s;

  initial begin
    if (NP < 2) $error("rasp_top: at least two ports needed");
    if (HPD_CYC < 1 || HPD_CYC > 65535) $error("rasp_top: hot plug count out of range");
  end

  rasp_sync #(.W(SW)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_tmds_clk_det, i_port_5v_detect, i_int_in, i_cfg_serial_data_in,
                i_cfg_serial_clock, i_strap_in}),
    .o_sync   (pins_s)
  );
  assign strap_s = pins_s[0];
  assign scl_s   = pins_s[1];
  assign sda_s   = pins_s[2];
  assign int_s   = pins_s[3];
  assign det5v_s = pins_s[4 +: NP];
  assign tmds_s  = pins_s[4 + NP +: NP];

  // ---------------------------------------------------------------
  // strap capture, sense output, boot and hot plug
  // ---------------------------------------------------------------
  logic [1:0]  wait_q, wait_d;
  logic        capt_q, capt_d;
  logic        addr_hi_q, addr_hi_d;
  logic        out_q, out_d;
  logic        reload_q, reload_d;
  logic        hpd_q, hpd_d;
  logic [15:0] hpd_cnt_q, hpd_cnt_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic        sense_mux;
  logic [6:0]  my_addr;

  // pick the status source for the selected port
  assign sense_mux = ctrl_q[rasp_pkg::CTRL_SEL_BIT] ? tmds_s[i_sel_port]
                                                     : det5v_s[i_sel_port];
  assign my_addr   = addr_hi_q ? rasp_pkg::ADDR_STRAP_HI[7:1]
                               : rasp_pkg::ADDR_STRAP_LO[7:1];

  // capture once the strap has crossed, then start boot and hot plug
  always_comb begin
    wait_d    = wait_q;
    capt_d    = capt_q;
    addr_hi_d = addr_hi_q;
    reload_d  = 1'b0;
    hpd_cnt_d = hpd_cnt_q;
    hpd_d     = hpd_q;
    out_d     = 1'b0;
    if (!capt_q) begin
      wait_d = wait_q + 2'h1;
      if (wait_q == rasp_pkg::CAPTURE_WAIT) begin
        capt_d    = 1'b1;
        addr_hi_d = strap_s;
        reload_d  = 1'b1;
        hpd_cnt_d = 16'(HPD_CYC);
      end
    end else begin
      out_d = sense_mux;
      if (hpd_cnt_q != 16'h0) begin
        hpd_cnt_d = hpd_cnt_q - 16'h1;
      end else begin
        hpd_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_q    <= 2'h0;
      capt_q    <= 1'b0;
      addr_hi_q <= 1'b0;
      reload_q  <= 1'b0;
      hpd_q     <= 1'b1;
      hpd_cnt_q <= 16'h0;
      out_q     <= 1'b0;
    end else begin
      wait_q    <= wait_d;
      capt_q    <= capt_d;
      addr_hi_q <= addr_hi_d;
      reload_q  <= reload_d;
      hpd_q     <= hpd_d;
      hpd_cnt_q <= hpd_cnt_d;
      out_q     <= out_d;
    end
  end

  assign o_strap_oe    = capt_q;
  assign o_strap_out   = out_q;
  assign o_boot_reload = reload_q;
  assign o_hpd_low     = hpd_q;

  // ---------------------------------------------------------------
  // open-drain interrupt
  // ---------------------------------------------------------------
  logic int_oe_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      int_oe_q <= 1'b0;
    end else begin
      int_oe_q <= i_int_req;
    end
  end
  assign o_int_out = 1'b0;
  assign o_int_oe  = int_oe_q;

  // ---------------------------------------------------------------
  // configuration serial target
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD} rasp_st_e;
  rasp_st_e   st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rdata;
  logic [3:0] cnt_q, cnt_d;
  logic       ack_q, ack_d, oe_q, oe_d, rw_q, rw_d, nack_q, nack_d;
  logic       scl_p_q, sda_p_q, rise, fall, start, stop;

  assign rise  = scl_s && !scl_p_q;
  assign fall  = !scl_s && scl_p_q;
  assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop  = scl_s && scl_p_q && !sda_p_q && sda_s;

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata = 8'h00;
    case (ptr_q)
      rasp_pkg::REG_CTRL: rdata = ctrl_q;
      rasp_pkg::REG_STAT: begin
        rdata[rasp_pkg::STAT_OUT_BIT]  = out_q;
        rdata[rasp_pkg::STAT_ADDR_BIT] = addr_hi_q;
        rdata[rasp_pkg::STAT_INT_BIT]  = int_s;
      end
      default:            rdata = 8'h00;
    endcase
  end

  // byte engine: shift on rise, act and drive on fall
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    cnt_d  = cnt_q;
    ack_d  = ack_q;
    oe_d   = oe_q;
    rw_d   = rw_q;
    nack_d = nack_q;
    ctrl_d = ctrl_q;
    if (start) begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d  = 1'b0;
    end else if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (rise && !ack_q) begin
        sh_d  = {sh_q[6:0], sda_s};
        cnt_d = cnt_q + 4'h1;
      end else if (rise) begin
        nack_d = sda_s;
      end
      if (fall && !ack_q && cnt_q == 4'h8) begin
        ack_d = 1'b1;
        cnt_d = 4'h0;
        case (st_q)
          ST_ADDR: begin
            if (sh_q[7:1] == my_addr) begin
              oe_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              st_d  = ST_IDLE;
              ack_d = 1'b0;
            end
          end
          ST_PTR: begin
            oe_d  = 1'b1;
            ptr_d = sh_q;
          end
          ST_WR: begin
            oe_d  = 1'b1;
            ptr_d = ptr_q + 8'h1;
            if (ptr_q == rasp_pkg::REG_CTRL) begin
              ctrl_d = sh_q;
            end
          end
          ST_RD:   oe_d = 1'b0;
          default: st_d = ST_IDLE;
        endcase
      end else if (fall && ack_q) begin
        ack_d = 1'b0;
        oe_d  = 1'b0;
        case (st_q)
          ST_ADDR: begin
            st_d = rw_q ? ST_RD : ST_PTR;
            if (rw_q) begin
              sh_d  = rdata;
              oe_d  = !rdata[7];
              ptr_d = ptr_q + 8'h1;
            end
          end
          ST_PTR:  st_d = ST_WR;
          ST_WR:   st_d = ST_WR;
          ST_RD: begin
            if (nack_q) begin
              st_d = ST_IDLE;
            end else begin
              sh_d  = rdata;
              oe_d  = !rdata[7];
              ptr_d = ptr_q + 8'h1;
            end
          end
          default: st_d = ST_IDLE;
        endcase
      end else if (fall && st_q == ST_RD) begin
        oe_d = !sh_q[7];  // open drain: drive low for a zero
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q    <= ST_IDLE;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      oe_q    <= 1'b0;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      ctrl_q  <= rasp_pkg::CTRL_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      cnt_q   <= cnt_d;
      ack_q   <= ack_d;
      oe_q    <= oe_d;
      rw_q    <= rw_d;
      nack_q  <= nack_d;
      ctrl_q  <= ctrl_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign o_cfg_serial_data_out = 1'b0;
  assign o_cfg_serial_data_oe  = oe_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_addr_match;
    st_q == ST_ADDR && fall && !ack_q && cnt_q == 4'h8 && sh_q[7:1] == my_addr;
  endsequence
  sequence s_addr_miss;
    st_q == ST_ADDR && fall && !ack_q && cnt_q == 4'h8 && sh_q[7:1] != my_addr;
  endsequence

  chk_strap_undriven: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !capt_q |-> !o_strap_oe) else $error("strap pin driven before capture");
  chk_strap_capture: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(capt_q) |-> addr_hi_q == $past(strap_s)) else $error("strap level not captured");
  chk_addr_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    capt_q && !addr_hi_q |-> my_addr == 7'h58) else $error("low strap address wrong");
  chk_addr_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
    capt_q && addr_hi_q |-> my_addr == 7'h59) else $error("high strap address wrong");
  chk_sense_5v: assert property (@(posedge i_clk) disable iff (!i_resetn)
    capt_q && !ctrl_q[rasp_pkg::CTRL_SEL_BIT] ##1 capt_q |-> o_strap_out == $past(sense_mux)
    && $past(sense_mux) == $past(det5v_s[i_sel_port])) else $error("5 V sense not shown");
  chk_sense_tmds: assert property (@(posedge i_clk) disable iff (!i_resetn)
    capt_q && ctrl_q[rasp_pkg::CTRL_SEL_BIT] |=> o_strap_out == $past(tmds_s[i_sel_port]))
    else $error("tmds activity not shown");
  chk_int_drain: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_int_req |=> o_int_oe && !o_int_out) else $error("interrupt not pulled low");
  chk_addr_ack: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_addr_match |=> o_cfg_serial_data_oe && ack_q) else $error("own address not acknowledged");
  chk_addr_ignore: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_addr_miss |=> !o_cfg_serial_data_oe && st_q == ST_IDLE) else $error("foreign frame answered");
  chk_boot_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(capt_q) |-> o_boot_reload && o_hpd_low ##1 !o_boot_reload) else $error("boot pulse wrong");
  chk_addr_stable: assert property (@(posedge i_clk) disable iff (!i_resetn)
    capt_q |=> $stable(addr_hi_q)) else $error("captured address changed");
endmodule // rasp_top

// ==== test/rasp_host.sv ====
/*
  host model on the configuration serial port: start, stop, bytes and
  register frames. assumes the data wire is resolved outside with a
  pull-up and the device sees both lines through synchronisers.
*/
`timescale 1ns/1ps
module rasp_host (
  // clock
  input  wire logic i_clk,
  // serial pins
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ---------------------------------------------------------------
  // line timing
  // ---------------------------------------------------------------
  // idle bus: clock high, data released
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  // lines change just after an edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // start (stp=0): data falls with clock high; stop (stp=1): data rises
  task automatic cond(input logic stp);
    wt(2);
    o_sda_oe = stp;
    wt(4);
    o_scl = 1'b1;
    wt(6);
    o_sda_oe = !stp;
    wt(6);
    o_scl = stp;
  endtask
  // nine bits msb first, ninth is the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      o_sda_oe = !tx[i];
      wt(4);
      o_scl = 1'b1;
      wt(3);
      rx[i] = i_sda;
      wt(3);
      o_scl = 1'b0;
    end
  endtask
  // ---------------------------------------------------------------
  // register frames
  // ---------------------------------------------------------------
  // write: address, pointer, data; ok when every byte was acked
  task automatic wr(input logic [7:0] a, p, d, output logic ok);
    logic [8:0] r0, r1, r2;
    cond(1'b0);
    xfer({a, 1'b1}, r0);
    xfer({p, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    cond(1'b1);
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask
  // read: pointer set, repeated start, one byte closed by no-ack
  task automatic rd(input logic [7:0] a, p, output logic [7:0] d, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    cond(1'b0);
    xfer({a, 1'b1}, r0);
    xfer({p, 1'b1}, r1);
    cond(1'b0);
    xfer({a | 8'h01, 1'b1}, r2);
    xfer(9'h1ff, r3);
    cond(1'b1);
    d  = r3[8:1];
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask
endmodule // rasp_host

// ==== test/rasp_tb.sv ====
/*
  self-checking bench: resets with both strap levels, register frames
  through the host model, sense muxing, interrupt pin, boot and hot plug.
  assumes pull-ups on interrupt and data wires, a resistor on the strap.
*/
`timescale 1ns/1ps
module rasp_tb;
  localparam int HPD = 2;  // shortened hot plug hold
  // ---------------------------------------------------------------
  // pins and model state
  // ---------------------------------------------------------------
  logic       i_clk, i_resetn, i_int_req, strap_lvl;
  logic [3:0] i_port_5v_detect, i_tmds_clk_det;
  logic [1:0] i_sel_port;
  logic       o_strap_out, o_strap_oe, o_int_out, o_int_oe, o_boot_reload, o_hpd_low;
  logic       o_cfg_serial_data_out, o_cfg_serial_data_oe, scl, host_oe, ok;
  logic [7:0] rnd_v, d, exp_addr, ctrl_m;
  int         fail_count, comparisons, n;
  // resolved wires: strap resistor, pull-ups on interrupt and data
  wire strap_pin = o_strap_oe ? o_strap_out : strap_lvl;
  wire int_pin   = !(o_int_oe && !o_int_out);
  wire sda_pin   = !(host_oe || (o_cfg_serial_data_oe && !o_cfg_serial_data_out));
  rasp_top #(.NP(4), .HPD_CYC(HPD)) u_dut (
    .i_clk                 (i_clk),
    .i_resetn              (i_resetn),
    .i_strap_in            (strap_pin),
    .o_strap_out           (o_strap_out),
    .o_strap_oe            (o_strap_oe),
    .i_port_5v_detect      (i_port_5v_detect),
    .i_tmds_clk_det        (i_tmds_clk_det),
    .i_sel_port            (i_sel_port),
    .i_int_req             (i_int_req),
    .i_int_in              (int_pin),
    .o_int_out             (o_int_out),
    .o_int_oe              (o_int_oe),
    .i_cfg_serial_clock    (scl),
    .i_cfg_serial_data_in  (sda_pin),
    .o_cfg_serial_data_out (o_cfg_serial_data_out),
    .o_cfg_serial_data_oe  (o_cfg_serial_data_oe),
    .o_boot_reload         (o_boot_reload),
    .o_hpd_low             (o_hpd_low)
  );
  rasp_host u_host (.i_clk(i_clk), .i_sda(sda_pin), .o_scl(scl), .o_sda_oe(host_oe));
  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = !i_clk;
  end
  // ---------------------------------------------------------------
  // helpers and model
  // ---------------------------------------------------------------
  task automatic wt(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // expected sense value from the selected source
  function automatic logic sense_m();
    return ctrl_m[0] ? i_tmds_clk_det[i_sel_port] : i_port_5v_detect[i_sel_port];
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset with a strap level, then follow capture, boot and hot plug
  task automatic do_reset(input logic lvl);
    i_resetn  = 1'b0;
    strap_lvl = lvl;
    wt(3);
    chk("strap_oe in reset", 8'h00, o_strap_oe);
    chk("hpd_low in reset", 8'h01, o_hpd_low);
    i_resetn = 1'b1;
    n = 0;
    while (o_boot_reload !== 1'b1 && n < 8) begin
      chk("strap_oe before capture", 8'h00, o_strap_oe);
      wt(1);
      n++;
    end
    chk("capture edge", 8'h03, n[7:0]);
    chk("strap_oe after capture", 8'h01, o_strap_oe);
    wt(1);
    chk("boot pulse end", 8'h00, o_boot_reload);
    strap_lvl = !lvl;  // a later strap change must not move the address
    chk("hpd_low held", 8'h01, o_hpd_low);
    wt(HPD);
    chk("hpd_low released", 8'h00, o_hpd_low);
  endtask
  // random port levels, every port selected in turn
  task automatic sense_chk();
    for (int i = 0; i < 6; i++) begin
      rnd_v            = nx(rnd_v);
      i_port_5v_detect = rnd_v[3:0];
      i_tmds_clk_det   = rnd_v[7:4];
      i_sel_port       = i[1:0];
      wt(4);
      chk("sense out", sense_m(), o_strap_out);
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    i_resetn         = 1'b0;
    strap_lvl        = 1'b0;
    i_int_req        = 1'b0;
    i_port_5v_detect = 4'h0;
    i_tmds_clk_det   = 4'h0;
    i_sel_port       = 2'h0;
    rnd_v            = 8'h59;
    fail_count       = 0;
    comparisons      = 0;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      ctrl_m   = 8'h00;
      exp_addr = s[0] ? rasp_pkg::ADDR_STRAP_HI : rasp_pkg::ADDR_STRAP_LO;
      u_host.wr(exp_addr ^ 8'h02, 8'h00, 8'hff, ok);
      chk("foreign address ack", 8'h00, ok);
      u_host.rd(exp_addr, rasp_pkg::REG_CTRL, d, ok);
      chk("control default", ctrl_m, d);
      for (int k = 0; k < 2; k++) begin
        rnd_v  = nx(rnd_v);
        ctrl_m = {rnd_v[7:1], k[0]};
        u_host.wr(exp_addr, rasp_pkg::REG_CTRL, ctrl_m, ok);
        chk("write ack", 8'h01, ok);
        u_host.rd(exp_addr, rasp_pkg::REG_CTRL, d, ok);
        chk("control readback", ctrl_m, d);
        sense_chk();
      end
      i_int_req = 1'b1;
      wt(1);
      chk("int pin pulled", 8'h00, int_pin);
      u_host.rd(exp_addr, rasp_pkg::REG_STAT, d, ok);
      chk("status", {5'h00, !i_int_req, s[0], sense_m()}, d);
      i_int_req = 1'b0;
      wt(1);
      chk("int pin floats", 8'h01, int_pin);
      chk("int data low", 8'h00, o_int_out);
    end
    end_sim();
  end
  // hang guard, far beyond the expected run
  initial begin
    #500000;
    fail_count++;
    end_sim();
  end
endmodule // rasp_tb
